// File: hw/qsw_config_regs.v
`include "qsw_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module qsw_config_regs #(
	parameter CLK_MHZ = `QSW_CLK_MHZ
) (
	input wire clk_sys,
	input wire reset_n,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	input wire [3:0] spi_on_bits,
	input wire [3:0] direct_in_pins,
	output reg [3:0] sense_enable_q,
	output reg current_sense_oe_n_q,
	output reg [11:0] low_threshold_code_q,
	output reg [3:0] high_threshold_select_q,
	output reg [7:0] blanking_time_code_q,
	output reg [3:0] low_detect_disable_q,
	output reg [3:0] open_load_disable_q,
	output reg [3:0] direct_ctrl_disable_q,
	output reg [3:0] and_mode_q,
	output reg [3:0] sense_ratio_select_q,
	output reg [3:0] fast_slew_select_q,
	output reg [3:0] switch_on_q,
	output reg uv_disable_q,
	output reg ov_disable_q,
	output reg [3:0] overtemp_latch_option_q,
	output reg [1:0] watchdog_timeout_code_q,
	output reg watchdog_restart_q,
	output reg [31:0] blanking_cycles_q,
	output reg [31:0] watchdog_cycles_q,
	output reg [15:0] high_trip_cycles_q
);

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	// Counts are in system clock cycles. Thirty-two bits hold the longest
	// watchdog period even at several hundred megahertz, so no count wraps.
	// The timers downstream load these values; keeping them as outputs
	// avoids a second copy of the table in that logic.
	localparam [31:0] HIGH_TRIP_CYC = `QSW_HIGH_TRIP_US * CLK_MHZ;
	localparam [31:0] BLANK_155_CYC = `QSW_BLANK_155_MS * 1000 * CLK_MHZ;
	localparam [31:0] BLANK_75_CYC = `QSW_BLANK_75_MS * 1000 * CLK_MHZ;
	localparam [31:0] BLANK_150_CYC = `QSW_BLANK_150_US * CLK_MHZ;
	localparam [31:0] WD_558_CYC = `QSW_WD_558_MS * 1000 * CLK_MHZ;
	localparam [31:0] WD_279_CYC = `QSW_WD_279_MS * 1000 * CLK_MHZ;
	localparam [31:0] WD_2250_CYC = `QSW_WD_2250_MS * 1000 * CLK_MHZ;
	localparam [31:0] WD_1125_CYC = `QSW_WD_1125_MS * 1000 * CLK_MHZ;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Every pin is asynchronous to clk_sys. The third stages of the link clock
	// and chip select only hold the previous settled level for edge detection;
	// nothing but the second stage reads the first.
	reg sclk_s1_q;
	reg sclk_s2_q;
	reg sclk_s3_q;
	reg cs_s1_q;
	reg cs_s2_q;
	reg cs_s3_q;
	reg mosi_s1_q;
	reg mosi_s2_q;
	reg [3:0] pin_s1_q;
	reg [3:0] pin_s2_q;
	wire sclk_rise;
	wire cs_rise;
	wire cs_low;

	// Two flops on each pin, a third on the link clock and chip select; edges are found from the second stage on.
	// Reset parks chip select high and the link clock low, their idle levels,
	// so no false edge follows reset.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			mosi_s1_q <= 1'b0;
			mosi_s2_q <= 1'b0;
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
		end else begin
			sclk_s1_q <= spi_sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			cs_s1_q <= spi_cs_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			mosi_s1_q <= spi_mosi;
			mosi_s2_q <= mosi_s1_q;
			pin_s1_q <= direct_in_pins;
			pin_s2_q <= pin_s1_q;
		end
	end

	// The data line is read from its second stage in the cycle the clock edge
	// is seen, so both paths carry equal delay. The link clock must stay high
	// and low for at least two system cycles each for this to hold.
	assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
	assign cs_rise = cs_s2_q & ~cs_s3_q;
	assign cs_low = ~cs_s2_q;

	// ----------------------------------------------------------------
	// Frame shifter
	// ----------------------------------------------------------------
	// The bit counter is four bits wide on purpose: it wraps on every sixteenth
	// bit, so a zero count at chip-select rise means a whole number of frames.
	// The any-bits flag rejects a chip-select pulse with no clock at all.
	reg [15:0] shift_q;
	reg [3:0] bit_cnt_q;
	reg any_bits_q;
	reg last_wd_q;
	wire frame_ok;
	wire [4:0] addr;
	wire [1:0] sel;
	wire [2:0] cmd;
	wire [3:0] data;
	wire is_sel_cmd;

	// MSB-first shift.
	// Only the last sixteen bits are kept, so a daisy chain of several
	// frames leaves this device the final word, as the chain intends.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			shift_q <= 16'h0000;
			bit_cnt_q <= 4'h0;
			any_bits_q <= 1'b0;
		end else if (cs_rise) begin
			bit_cnt_q <= 4'h0;
			any_bits_q <= 1'b0;
		end else if (cs_low && sclk_rise) begin
			shift_q <= {shift_q[14:0], mosi_s2_q};
			bit_cnt_q <= bit_cnt_q + 4'h1;
			any_bits_q <= 1'b1;
		end
	end

	assign frame_ok = cs_rise && any_bits_q && (bit_cnt_q == 4'h0);

	// The five address bits are the output select above the three command
	// bits; the fixed registers use all five bits as their address.
	assign addr = shift_q[`QSW_ADDR_HI:`QSW_ADDR_LO];
	assign sel = shift_q[`QSW_SEL_HI:`QSW_SEL_LO];
	assign cmd = addr[2:0];
	assign data = shift_q[3:0];
	assign is_sel_cmd = (cmd == `QSW_CMD_THRESH) || (cmd == `QSW_CMD_DETECT) ||
		(cmd == `QSW_CMD_DIRECT);

	// ----------------------------------------------------------------
	// Shared registers
	// ----------------------------------------------------------------
	// Unused addresses leave every register here untouched; only the
	// watchdog reference bit follows them. A write lands one cycle after
	// the commit strobe and holds until the next valid frame or reset.
	// Address decode.
	// No-action untouched: the no-op address matches no branch.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			sense_enable_q <= `QSW_RESET_NIB;
			uv_disable_q <= 1'b0;
			ov_disable_q <= 1'b0;
			overtemp_latch_option_q <= `QSW_RESET_NIB;
			watchdog_timeout_code_q <= 2'h0;
		end else if (frame_ok) begin
			if (addr == `QSW_ADDR_SENSE) begin
				sense_enable_q <= data;
			end else if (addr == `QSW_ADDR_VPROT) begin
				uv_disable_q <= data[`QSW_VP_UV_DIS];
				ov_disable_q <= data[`QSW_VP_OV_DIS];
				overtemp_latch_option_q[1:0] <= data[3:2];
			end else if (addr == `QSW_ADDR_WDOG) begin
				overtemp_latch_option_q[3:2] <= data[3:2];
				watchdog_timeout_code_q <= data[1:0];
			end
		end
	end

	// The enable lags the register by one cycle. The pad is released only
	// when no output is routed, so it never fights another driver on a shared line.
	// Tri-state sense pin.
	// Summing is analog; any set bit keeps the pin driven.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			current_sense_oe_n_q <= 1'b1;
		end else begin
			current_sense_oe_n_q <= (sense_enable_q == 4'h0);
		end
	end

	// ----------------------------------------------------------------
	// Per-output registers
	// ----------------------------------------------------------------
	// One copy of the selected-output fields per output. A frame reaches only
	// the copy whose index equals the select bits, so the others keep their values.
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_out
			wire hit;
			assign hit = frame_ok && is_sel_cmd && (sel == g);
			always @(posedge clk_sys) begin
				if (!reset_n) begin
					low_threshold_code_q[3*g+2:3*g] <= 3'h0;
					high_threshold_select_q[g] <= 1'b0;
					blanking_time_code_q[2*g+1:2*g] <= 2'h0;
					low_detect_disable_q[g] <= 1'b0;
					open_load_disable_q[g] <= 1'b0;
					direct_ctrl_disable_q[g] <= 1'b0;
					and_mode_q[g] <= 1'b0;
					sense_ratio_select_q[g] <= 1'b0;
					fast_slew_select_q[g] <= 1'b0;
				end else if (hit && cmd == `QSW_CMD_THRESH) begin
					low_threshold_code_q[3*g+2:3*g] <= data[2:0];
					high_threshold_select_q[g] <= data[`QSW_THR_HIGH];
				end else if (hit && cmd == `QSW_CMD_DETECT) begin
					blanking_time_code_q[2*g+1:2*g] <= data[1:0];
					low_detect_disable_q[g] <= data[`QSW_DET_OCL_DIS];
					open_load_disable_q[g] <= data[`QSW_DET_OL_DIS];
				end else if (hit && cmd == `QSW_CMD_DIRECT) begin
					direct_ctrl_disable_q[g] <= data[`QSW_DIR_DIS];
					and_mode_q[g] <= data[`QSW_DIR_AND];
					sense_ratio_select_q[g] <= data[`QSW_DIR_RATIO];
					fast_slew_select_q[g] <= data[`QSW_DIR_FAST];
				end
			end

			// The SPI on bits come from logic on clk_sys and need no synchroniser;
			// the parallel pins are read after their two stages.
			// Gate pin with SPI bit.
			always @(posedge clk_sys) begin
				if (!reset_n) begin
					switch_on_q[g] <= 1'b0;
				end else if (direct_ctrl_disable_q[g]) begin
					switch_on_q[g] <= spi_on_bits[g];
				end else if (and_mode_q[g]) begin
					switch_on_q[g] <= spi_on_bits[g] & pin_s2_q[g];
				end else begin
					switch_on_q[g] <= spi_on_bits[g] | pin_s2_q[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Watchdog restart and timing counts
	// ----------------------------------------------------------------
	// A refused frame never moves the reference bit, so it cannot pass for a
	// toggle. The pulse lasts one cycle; the timer it restarts must sample it
	// on every clock.
	// Toggle restarts.
	// The first frame after reset compares with a zero reference bit.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			last_wd_q <= 1'b0;
			watchdog_restart_q <= 1'b0;
		end else begin
			watchdog_restart_q <= frame_ok && (shift_q[`QSW_WD_BIT] != last_wd_q);
			if (frame_ok) begin
				last_wd_q <= shift_q[`QSW_WD_BIT];
			end
		end
	end

	// Code 01 is not a legal blanking setting; a count of zero makes a wrong
	// host setting easy to spot instead of timing silently.
	// Blanking count.
	// Timeout count.
	// Counts are shown for output 0's blanking; code 01 yields zero.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			blanking_cycles_q <= 32'h0;
			watchdog_cycles_q <= 32'h0;
			high_trip_cycles_q <= 16'h0;
		end else begin
			high_trip_cycles_q <= HIGH_TRIP_CYC[15:0];
			case (blanking_time_code_q[1:0])
				2'h0: blanking_cycles_q <= BLANK_155_CYC;
				2'h2: blanking_cycles_q <= BLANK_75_CYC;
				2'h3: blanking_cycles_q <= BLANK_150_CYC;
				default: blanking_cycles_q <= 32'h0;
			endcase
			case (watchdog_timeout_code_q)
				2'h0: watchdog_cycles_q <= WD_558_CYC;
				2'h1: watchdog_cycles_q <= WD_279_CYC;
				2'h2: watchdog_cycles_q <= WD_2250_CYC;
				default: watchdog_cycles_q <= WD_1125_CYC;
			endcase
		end
	end

endmodule // qsw_config_regs

`default_nettype wire

// File: hw/qsw_consts.vh
`ifndef QSW_CONSTS_VH
`define QSW_CONSTS_VH
// Frame layout.
`define QSW_FRAME_BITS 16
`define QSW_WD_BIT 15
`define QSW_SEL_HI 12
`define QSW_SEL_LO 11
`define QSW_ADDR_HI 12
`define QSW_ADDR_LO 8
// Register addresses, five bits {D12..D8}; command codes, three bits {D10..D8}.
`define QSW_ADDR_VPROT 5'h05
`define QSW_ADDR_NOOP 5'h06
`define QSW_ADDR_SENSE 5'h09
`define QSW_ADDR_WDOG 5'h0d
`define QSW_CMD_THRESH 3'h2
`define QSW_CMD_DETECT 3'h3
`define QSW_CMD_DIRECT 3'h4
// Field positions.
`define QSW_THR_HIGH 3
`define QSW_DET_OL_DIS 3
`define QSW_DET_OCL_DIS 2
`define QSW_DIR_FAST 3
`define QSW_DIR_RATIO 2
`define QSW_DIR_DIS 1
`define QSW_DIR_AND 0
`define QSW_VP_UV_DIS 1
`define QSW_VP_OV_DIS 0
// Reset value of every configuration field.
`define QSW_RESET_NIB 4'h0
// Timing.
`define QSW_CLK_MHZ 100
`define QSW_HIGH_TRIP_US 20
`define QSW_BLANK_155_MS 155
`define QSW_BLANK_75_MS 75
`define QSW_BLANK_150_US 150
`define QSW_WD_558_MS 558
`define QSW_WD_279_MS 279
`define QSW_WD_2250_MS 2250
`define QSW_WD_1125_MS 1125
`endif

// File: tb/qsw_config_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Port checker
// ----------------------------
module qsw_config_regs_monitor #(
	parameter CLK_MHZ = 100
) (
	input wire clk_sys,
	input wire reset_n,
	input wire spi_cs_n,
	input wire [3:0] spi_on_bits,
	input wire [3:0] direct_in_pins,
	input wire [3:0] sense_enable_q,
	input wire current_sense_oe_n_q,
	input wire [7:0] blanking_time_code_q,
	input wire [3:0] direct_ctrl_disable_q,
	input wire [3:0] and_mode_q,
	input wire [3:0] switch_on_q,
	input wire uv_disable_q,
	input wire [1:0] watchdog_timeout_code_q,
	input wire watchdog_restart_q,
	input wire [31:0] blanking_cycles_q,
	input wire [31:0] watchdog_cycles_q,
	input wire [15:0] high_trip_cycles_q
);
	// Times in microseconds, scaled by the clock rate so a slower clock still checks.
	function automatic logic [31:0] wd_us(input logic [1:0] c);
		case (c)
			2'h0: return 32'h883b0;
			2'h1: return 32'h441d8;
			2'h2: return 32'h225510;
			default: return 32'h112a88;
		endcase
	endfunction
	function automatic logic [31:0] blk_us(input logic [7:0] c);
		case (c[1:0])
			2'h0: return 32'h25d78;
			2'h2: return 32'h124f8;
			2'h3: return 32'h96;
			default: return 32'h0;
		endcase
	endfunction
	// Expected drive when pin and SPI bit are combined.
	wire [3:0] mix_w = (direct_ctrl_disable_q & spi_on_bits)
		| (~direct_ctrl_disable_q & and_mode_q & spi_on_bits & direct_in_pins)
		| (~direct_ctrl_disable_q & ~and_mode_q & (spi_on_bits | direct_in_pins));
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	reset_clear_a:
		assert property (!$past(reset_n) |-> sense_enable_q == 4'h0 && current_sense_oe_n_q
			&& watchdog_timeout_code_q == 2'h0 && switch_on_q == 4'h0) else $error("reset state");
	sense_float_a:
		assert property ($past(reset_n) |-> current_sense_oe_n_q == ($past(sense_enable_q) == 4'h0))
		else $error("sense enable wrong");
	pulse_once_a:
		assert property (watchdog_restart_q |=> !watchdog_restart_q) else $error("restart too long");
	restart_after_cs_a:
		assert property (watchdog_restart_q |-> $past(spi_cs_n, 2)) else $error("restart mid frame");
	quiet_frame_a:
		assert property ((!spi_cs_n) [*8] |-> $stable(sense_enable_q) && $stable(uv_disable_q)
			&& $stable(watchdog_timeout_code_q)) else $error("change inside frame");
	high_trip_a:
		assert property ($past(reset_n) |-> high_trip_cycles_q == 20 * CLK_MHZ)
		else $error("high trip count");
	wd_count_a:
		assert property ($past(reset_n) |-> watchdog_cycles_q
			== wd_us($past(watchdog_timeout_code_q)) * CLK_MHZ) else $error("watchdog count");
	blank_count_a:
		assert property ($past(reset_n) |-> blanking_cycles_q
			== blk_us($past(blanking_time_code_q)) * CLK_MHZ) else $error("blanking count");
	switch_mix_a:
		assert property (($stable(spi_on_bits) && $stable(direct_in_pins) && $stable(and_mode_q)
			&& $stable(direct_ctrl_disable_q)) [*6] |-> switch_on_q == mix_w)
		else $error("switch drive");
	cover property (watchdog_restart_q);
	cover property (!current_sense_oe_n_q);
	cover property (switch_on_q != 4'h0);
endmodule // qsw_config_regs_monitor
bind qsw_config_regs qsw_config_regs_monitor #(.CLK_MHZ(CLK_MHZ)) mon (
	.clk_sys(clk_sys),
	.reset_n(reset_n),
	.spi_cs_n(spi_cs_n),
	.spi_on_bits(spi_on_bits),
	.direct_in_pins(direct_in_pins),
	.sense_enable_q(sense_enable_q),
	.current_sense_oe_n_q(current_sense_oe_n_q),
	.blanking_time_code_q(blanking_time_code_q),
	.direct_ctrl_disable_q(direct_ctrl_disable_q),
	.and_mode_q(and_mode_q),
	.switch_on_q(switch_on_q),
	.uv_disable_q(uv_disable_q),
	.watchdog_timeout_code_q(watchdog_timeout_code_q),
	.watchdog_restart_q(watchdog_restart_q),
	.blanking_cycles_q(blanking_cycles_q),
	.watchdog_cycles_q(watchdog_cycles_q),
	.high_trip_cycles_q(high_trip_cycles_q)
);
`default_nettype wire

// File: tb/qsw_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Host SPI master, mode 0
// ----------------------------
module qsw_spi_host (
	output logic sclk,
	output logic cs_n,
	output logic mosi
);
	// Clock rests low and select high between frames.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// Bit period 160 ns, offset so its edges keep a fixed distance from the system clock edges.
	task automatic send(input logic [31:0] bits, input int n);
		int i;
		cs_n = 1'b0;
		#83;
		for (i = n - 1; i >= 0; i--) begin
			mosi = bits[i];
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
		#40 cs_n = 1'b1;
		// No pull on the data line, so a released line must not echo its last bit.
		mosi = ~mosi;
		#80;
	endtask
endmodule // qsw_spi_host
`default_nettype wire

// File: tb/test_qsw_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Bench
// ----------------------------
module test_qsw_config_regs;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] spi_on_bits = 4'h0;
	logic [3:0] direct_in_pins = 4'h0;
	logic wd = 1'b0;
	int err_total = 0;
	int check_count = 0;
	int restarts = 0;
	wire spi_sclk, spi_cs_n, spi_mosi, current_sense_oe_n_q, uv_disable_q, ov_disable_q;
	wire watchdog_restart_q;
	wire [3:0] sense_enable_q, high_threshold_select_q, low_detect_disable_q, open_load_disable_q;
	wire [3:0] direct_ctrl_disable_q, and_mode_q, sense_ratio_select_q, fast_slew_select_q;
	wire [3:0] switch_on_q, overtemp_latch_option_q;
	wire [11:0] low_threshold_code_q;
	wire [7:0] blanking_time_code_q;
	wire [1:0] watchdog_timeout_code_q;
	qsw_config_regs dut (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.spi_on_bits(spi_on_bits),
		.direct_in_pins(direct_in_pins),
		.sense_enable_q(sense_enable_q),
		.current_sense_oe_n_q(current_sense_oe_n_q),
		.low_threshold_code_q(low_threshold_code_q),
		.high_threshold_select_q(high_threshold_select_q),
		.blanking_time_code_q(blanking_time_code_q),
		.low_detect_disable_q(low_detect_disable_q),
		.open_load_disable_q(open_load_disable_q),
		.direct_ctrl_disable_q(direct_ctrl_disable_q),
		.and_mode_q(and_mode_q),
		.sense_ratio_select_q(sense_ratio_select_q),
		.fast_slew_select_q(fast_slew_select_q),
		.switch_on_q(switch_on_q),
		.uv_disable_q(uv_disable_q),
		.ov_disable_q(ov_disable_q),
		.overtemp_latch_option_q(overtemp_latch_option_q),
		.watchdog_timeout_code_q(watchdog_timeout_code_q),
		.watchdog_restart_q(watchdog_restart_q),
		.blanking_cycles_q(),
		.watchdog_cycles_q(),
		.high_trip_cycles_q()
	);
	qsw_spi_host host (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi));
	// System clock, 10 ns period.
	always #5 clk_sys = ~clk_sys;
	// Restart pulses last one cycle, so they are counted rather than sampled.
	always @(posedge clk_sys) if (watchdog_restart_q === 1'b1) restarts <= restarts + 1;
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One frame, then enough cycles for sync, commit and output stages.
	task automatic wr(input logic [4:0] a, input logic [3:0] d, input logic tog);
		wd = wd ^ tog;
		@(posedge clk_sys) #1;
		host.send({wd, 2'h0, a, 4'h0, d}, 16);
		repeat (10) @(posedge clk_sys);
		#1;
	endtask
	task automatic t_reset();
		check("sense", sense_enable_q, 4'h0);
		check("oe_n", current_sense_oe_n_q, 1'b1);
		check("low", low_threshold_code_q, 12'h000);
		check("det", {blanking_time_code_q, low_detect_disable_q, open_load_disable_q}, 16'h0);
		check("vp", {overtemp_latch_option_q, uv_disable_q, ov_disable_q}, 6'h00);
	endtask
	task automatic t_sense();
		wr(5'h09, 4'h9, 1'b0);
		check("sense", sense_enable_q, 4'h9);
		check("oe_n", current_sense_oe_n_q, 1'b0);
		wr(5'h09, 4'h0, 1'b0);
		check("oe_n", current_sense_oe_n_q, 1'b1);
	endtask
	task automatic t_outputs();
		logic [3:0] th [4];
		logic [3:0] dt [4];
		logic [3:0] dr [4];
		int g;
		for (g = 0; g < 4; g++) begin
			th[g] = {g[0], 3'(g + 5)};
			dt[g] = {g[1], g[0], g == 2 ? 2'h0 : {1'b1, ~g[0]}};
			dr[g] = {g[1], ~g[0], g[0], g[1] ^ g[0]};
			wr({g[1:0], 3'h2}, th[g], 1'b0);
			wr({g[1:0], 3'h3}, dt[g], 1'b0);
			wr({g[1:0], 3'h4}, dr[g], 1'b0);
		end
		for (g = 0; g < 4; g++) begin
			check("low", low_threshold_code_q[3*g +: 3], th[g][2:0]);
			check("high", high_threshold_select_q[g], th[g][3]);
			check("blank", blanking_time_code_q[2*g +: 2], dt[g][1:0]);
			check("ocl", low_detect_disable_q[g], dt[g][2]);
			check("ol", open_load_disable_q[g], dt[g][3]);
			check("ratio", sense_ratio_select_q[g], dr[g][2]);
			check("slew", fast_slew_select_q[g], dr[g][3]);
			check("dir", {direct_ctrl_disable_q[g], and_mode_q[g]}, dr[g][1:0]);
		end
	endtask
	// Outputs 1 and 3 ignore the pin, 0 ORs and 2 ANDs after t_outputs.
	task automatic t_gating();
		logic [3:0] ex;
		int k;
		for (k = 0; k < 4; k++) begin
			@(posedge clk_sys) #1;
			spi_on_bits = {4{k[0]}};
			direct_in_pins = {4{k[1]}};
			repeat (8) @(posedge clk_sys);
			#1;
			ex = (4'ha & spi_on_bits) | (4'h4 & spi_on_bits & direct_in_pins)
				| (4'h1 & (spi_on_bits | direct_in_pins));
			check("switch", switch_on_q, ex);
		end
	endtask
	task automatic t_vwd();
		int k;
		int n;
		wr(5'h05, 4'hf, 1'b0);
		check("uv ov", {uv_disable_q, ov_disable_q}, 2'h3);
		check("latch lo", overtemp_latch_option_q[1:0], 2'h3);
		for (k = 0; k < 4; k++) begin
			n = restarts;
			wr(5'h0d, {2'h3, k[1:0]}, 1'b1);
			check("wd", watchdog_timeout_code_q, k[1:0]);
			check("restart", restarts - n, 1);
		end
		check("latch", overtemp_latch_option_q, 4'hf);
	endtask
	// A no-op with toggle, a short frame and a double frame.
	task automatic t_refuse();
		int n;
		n = restarts;
		// The no-op ends in a zero, so a short frame kept by mistake would
		// carry a toggled watchdog bit and show up as an extra restart.
		wr(5'h06, 4'he, 1'b1);
		check("restart", restarts - n, 1);
		check("uv ov", {uv_disable_q, ov_disable_q}, 2'h3);
		check("sense", sense_enable_q, 4'h0);
		@(posedge clk_sys) #1;
		host.send({~wd, 2'h0, 5'h09, 8'h0f}, 15);
		repeat (10) @(posedge clk_sys);
		#1;
		check("sense", sense_enable_q, 4'h0);
		check("restart", restarts - n, 1);
		@(posedge clk_sys) #1;
		host.send({wd, 15'h0600, wd, 15'h0903}, 32);
		repeat (10) @(posedge clk_sys);
		#1;
		check("sense", sense_enable_q, 4'h3);
	endtask
	task automatic t_rereset();
		@(posedge clk_sys) #1;
		reset_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		t_reset();
	endtask
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		t_reset();
		t_sense();
		t_outputs();
		t_gating();
		t_vwd();
		t_refuse();
		t_rereset();
		complete_run();
	end
	// About 22 frames of 3 us each; this limit leaves ample margin.
	initial begin
		#500000;
		err_total++;
		complete_run();
	end
endmodule // test_qsw_config_regs
`default_nettype wire
